// ==== ums_top.sv ====
// Modem interrupt, auto clear-to-send transmitter and line status flags.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

module ums_top #(
  parameter int CLKS_PER_BIT = ums_pkg::CLKS_PER_BIT
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Register port.
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Modem pins, active low, asynchronous.
  input  wire logic        i_cts_n,
  input  wire logic        i_dsr_n,
  input  wire logic        i_ri_n,
  input  wire logic        i_dcd_n,
  // Transmit FIFO side.
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_data,
  output logic             o_tx_take,
  output logic             o_txd,
  output logic             o_tx_stalled,
  // Receive side.
  input  wire logic        i_rx_done,
  input  wire logic        i_rx_parity_bad,
  input  wire logic        i_rx_head_new,
  input  wire logic        i_rx_head_parity_bad,
  input  wire logic        i_rx_fifo_full,
  input  wire logic        i_rx_fifo_empty,
  output logic             o_rx_push,
  // Interrupts.
  output logic             o_modem_irq,
  output logic             o_irq
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (CLKS_PER_BIT < 2 || CLKS_PER_BIT > 65535) begin : g_bad_rate
      $error("CLKS_PER_BIT must lie between 2 and 65535.");
    end
  endgenerate

  localparam logic [15:0] BIT_LAST = 16'(CLKS_PER_BIT - 1);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0]      pin_s1;
    logic [3:0]      pin_s2;
    logic [3:0]      pin_prev;
    logic [3:0]      delta;
    logic            cts_irq_en;
    logic            msi_en;
    logic            auto_cts;
    logic            fifo_en;
    logic [3:0]      ev_stat;
    logic [3:0]      ev_mask;
    logic            rx_data_ready;
    logic            oe;
    logic            pe;
    ums_pkg::ums_tx_e tx_st;
    logic [2:0]      bit_cnt;
    logic [15:0]     baud;
    logic [7:0]      shift;
    logic            txd;
    logic            stalled;
    logic [7:0]      rdata;
  } ums_state_s;

  ums_state_s st;
  ums_state_s next_st;

  // Pin order in the synchroniser: cts, dsr, ri, dcd.
  logic [3:0] pins_raw;
  logic       cts_active;
  logic       tx_go;
  logic       bit_end;
  logic       rd_lsr;
  logic       rd_msr;
  logic       rd_ev;
  logic [3:0] new_delta;
  logic [3:0] new_ev;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic       modem_cond;

  assign pins_raw   = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
  assign cts_active = ~st.pin_s2[0];
  assign bit_end    = (st.baud == BIT_LAST);
  assign rd_lsr     = i_rd && (i_addr == ums_pkg::LINE_STATUS_OFS);
  assign rd_msr     = i_rd && (i_addr == ums_pkg::MODEM_STATUS_OFS);
  assign rd_ev      = i_rd && (i_addr == ums_pkg::EVENT_STATUS_OFS);

  // ****************************************************************
  // Modem status interrupt
  // ****************************************************************
  // The CTS delta counts only without auto CTS or with its own enable.
  assign modem_cond = (|st.delta[3:1])
                    || (st.delta[0] && (!st.auto_cts
                    || st.cts_irq_en));
  assign o_modem_irq = st.msi_en && modem_cond;

  // ****************************************************************
  // Transmitter start decision
  // ****************************************************************
  // A character starts only from idle, so one in flight always finishes.
  assign tx_go = (st.tx_st == ums_pkg::TX_IDLE) && i_tx_valid
               && (!st.auto_cts
               || cts_active);
  assign o_tx_take    = tx_go;
  assign o_txd        = st.txd;
  assign o_tx_stalled = st.stalled;

  // ****************************************************************
  // Receive side
  // ****************************************************************
  // A completed character is pushed only when there is room for it.
  assign o_rx_push = i_rx_done && !i_rx_fifo_full;

  // Status views assembled for reads.
  assign lsr_val = {1'b0,
                    (st.tx_st == ums_pkg::TX_IDLE) && !i_tx_valid,
                    !i_tx_valid,
                    2'b00,
                    st.pe,
                    st.oe,
                    st.rx_data_ready};
  assign msr_val = {~st.pin_s2[3], ~st.pin_s2[2], ~st.pin_s2[1],
                    ~st.pin_s2[0], st.delta[3], st.delta[2],
                    st.delta[1], st.delta[0]};

  assign o_rdata = st.rdata;
  assign o_irq   = |(st.ev_stat & st.ev_mask);

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Computes every field of the next state from the present one.
  always_comb begin
    next_st = st;

    // Two-flop synchroniser; only the second stage feeds logic.
    next_st.pin_s1   = pins_raw;
    next_st.pin_s2   = st.pin_s1;
    next_st.pin_prev = st.pin_s2;

    // Delta flags: change on CTS, DSR, DCD; RI only on its trailing edge.
    new_delta[0] = st.pin_s2[0] ^ st.pin_prev[0];
    new_delta[1] = st.pin_s2[1] ^ st.pin_prev[1];
    new_delta[2] = st.pin_s2[2] && !st.pin_prev[2];
    new_delta[3] = st.pin_s2[3] ^ st.pin_prev[3];
    if (rd_msr) begin
      next_st.delta = 4'h0;
    end
    next_st.delta = next_st.delta | new_delta;

    // Software writes of control registers.
    if (i_wr) begin
      case (i_addr)
        ums_pkg::IRQ_ENABLE_OFS: begin
          next_st.cts_irq_en = i_wdata[ums_pkg::CTS_IRQ_EN_BIT];
        end
        ums_pkg::IRQ_ENABLE_ALT_OFS: begin
          next_st.msi_en = i_wdata[ums_pkg::MSI_EN_BIT];
        end
        ums_pkg::MODEM_CONTROL_OFS: begin
          next_st.auto_cts = i_wdata[ums_pkg::AUTO_CTS_BIT];
        end
        ums_pkg::FIFO_CONTROL_OFS: begin
          next_st.fifo_en = i_wdata[ums_pkg::FIFO_EN_BIT];
        end
        ums_pkg::EVENT_MASK_OFS: begin
          next_st.ev_mask = i_wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // Data ready mirrors the receive FIFO holding a character.
    next_st.rx_data_ready = !i_rx_fifo_empty;

    // Overrun and parity flags clear on a line status read; a new
    // event in the same cycle still sets them.
    if (rd_lsr) begin
      next_st.oe = 1'b0;
      next_st.pe = 1'b0;
    end
    if (i_rx_done && i_rx_fifo_full) begin
      next_st.oe = 1'b1;
    end
    // With the FIFO on, parity shows when the character reaches the head.
    if (st.fifo_en) begin
      if (i_rx_head_new && i_rx_head_parity_bad) begin
        next_st.pe = 1'b1;
      end
    end else if (i_rx_done && i_rx_parity_bad) begin
      next_st.pe = 1'b1;
    end

    // Transmitter serialiser.
    next_st.baud = bit_end ? 16'h0000 : st.baud + 16'h0001;
    case (st.tx_st)
      ums_pkg::TX_IDLE: begin
        next_st.txd  = 1'b1;
        next_st.baud = 16'h0000;
        next_st.stalled = i_tx_valid && st.auto_cts && !cts_active;
        if (tx_go) begin
          next_st.shift = i_tx_data;
          next_st.txd   = 1'b0;
          next_st.tx_st = ums_pkg::TX_START;
        end
      end
      ums_pkg::TX_START: begin
        if (bit_end) begin
          next_st.txd     = st.shift[0];
          next_st.shift   = {1'b0, st.shift[7:1]};
          next_st.bit_cnt = 3'h0;
          next_st.tx_st   = ums_pkg::TX_DATA;
        end
      end
      ums_pkg::TX_DATA: begin
        if (bit_end) begin
          if (st.bit_cnt == 3'h7) begin
            next_st.txd   = 1'b1;
            next_st.tx_st = ums_pkg::TX_STOP;
          end else begin
            next_st.txd     = st.shift[0];
            next_st.shift   = {1'b0, st.shift[7:1]};
            next_st.bit_cnt = st.bit_cnt + 3'h1;
          end
        end
      end
      ums_pkg::TX_STOP: begin
        // CTS is looked at again only once this stop bit has ended.
        if (bit_end) begin
          next_st.tx_st = ums_pkg::TX_IDLE;
        end
      end
      default: begin
        next_st.tx_st = ums_pkg::TX_IDLE;
        next_st.txd   = 1'b1;
      end
    endcase

    // Sticky events; a read clears, a same-cycle event wins.
    new_ev = 4'h0;
    new_ev[ums_pkg::EV_OVERRUN] = i_rx_done && i_rx_fifo_full;
    new_ev[ums_pkg::EV_PARITY]  = next_st.pe && !st.pe;
    new_ev[ums_pkg::EV_MODEM]   = |new_delta;
    new_ev[ums_pkg::EV_STALL]   = next_st.stalled && !st.stalled;
    if (rd_ev) begin
      next_st.ev_stat = 4'h0;
    end
    next_st.ev_stat = next_st.ev_stat | new_ev;

    // Read data for the cycle after the strobe.
    next_st.rdata = ums_pkg::REG_RESET;
    if (i_rd) begin
      case (i_addr)
        ums_pkg::LINE_STATUS_OFS: begin
          next_st.rdata = lsr_val;
        end
        ums_pkg::MODEM_STATUS_OFS: begin
          next_st.rdata = msr_val;
        end
        ums_pkg::IRQ_ENABLE_OFS: begin
          next_st.rdata = {st.cts_irq_en, 7'h00};
        end
        ums_pkg::IRQ_ENABLE_ALT_OFS: begin
          next_st.rdata = {4'h0, st.msi_en, 3'h0};
        end
        ums_pkg::MODEM_CONTROL_OFS: begin
          next_st.rdata = {st.auto_cts, 7'h00};
        end
        ums_pkg::EVENT_STATUS_OFS: begin
          next_st.rdata = {4'h0, st.ev_stat};
        end
        ums_pkg::EVENT_MASK_OFS: begin
          next_st.rdata = {4'h0, st.ev_mask};
        end
        default: begin
          next_st.rdata = ums_pkg::REG_RESET;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset puts every field at a constant.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st            <= '0;
      st.pin_s1     <= ums_pkg::PIN_IDLE;
      st.pin_s2     <= ums_pkg::PIN_IDLE;
      st.pin_prev   <= ums_pkg::PIN_IDLE;
      st.tx_st      <= ums_pkg::TX_IDLE;
      st.txd        <= 1'b1;
      st.rdata      <= ums_pkg::REG_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule : ums_top

// ==== ums_pkg.sv ====
// Constants, register map and types for the modem interrupt and line status block.
//
// Summary of operation
// - No modem interrupt while master enable clear
// - DCD, RI trailing, DSR deltas always interrupt
// - Auto CTS off: CTS delta interrupts
// - Auto CTS on: CTS delta needs enable
// - Auto CTS off: transmit regardless of CTS
// - CTS lost: finish character, then stall
// - Stalled transmitter holds line at one
// - CTS back: start bit, then data
// - Data ready follows receive FIFO not empty
// - Overrun set when full FIFO meets character
// - Overrun keeps FIFO, drops new character
// - Line status read clears overrun
// - Bad parity sets flag, read clears
// - Parity flag follows head, FIFO enable
// - Line status read only, flags reset zero
// - Auto CTS still sets CTS delta
// - Sample CTS before each byte, send low
package ums_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [31:0] IRQ_ENABLE_OFS     = 32'h4000_8004;
  localparam logic [31:0] FIFO_CONTROL_OFS   = 32'h4000_8008;
  localparam logic [31:0] MODEM_CONTROL_OFS  = 32'h4000_8010;
  localparam logic [31:0] LINE_STATUS_OFS    = 32'h4000_8014;
  localparam logic [31:0] MODEM_STATUS_OFS   = 32'h4000_8018;
  localparam logic [31:0] IRQ_ENABLE_ALT_OFS = 32'h4000_8054;
  localparam logic [31:0] EVENT_STATUS_OFS   = 32'h4000_8060;
  localparam logic [31:0] EVENT_MASK_OFS     = 32'h4000_8064;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTS_IRQ_EN_BIT   = 7;
  localparam int MSI_EN_BIT       = 3;
  localparam int AUTO_CTS_BIT     = 7;
  localparam int FIFO_EN_BIT      = 0;
  localparam int LSR_RDR_BIT      = 0;
  localparam int LSR_OE_BIT       = 1;
  localparam int LSR_PE_BIT       = 2;
  localparam int LSR_TX_HOLD_BIT  = 5;
  localparam int LSR_TX_EMPTY_BIT = 6;

  // Event bits of the sticky status register.
  localparam int EV_OVERRUN = 0;
  localparam int EV_PARITY  = 1;
  localparam int EV_MODEM   = 2;
  localparam int EV_STALL   = 3;

  // ****************************************************************
  // Reset values and defaults
  // ****************************************************************
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [3:0]  PIN_IDLE     = 4'hf;
  localparam int          CLKS_PER_BIT = 16;

  // ****************************************************************
  // Transmitter states
  // ****************************************************************
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } ums_tx_e;

endpackage : ums_pkg

// ==== ums_checker.sv ====
// Assertions on the ports of the modem interrupt and line status block.
`timescale 1ns/1ps

module ums_checker #(
  parameter int CLKS_PER_BIT = 16
) (
  // Clock, reset and register port.
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [31:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  // Transmit and receive sides.
  input wire logic        o_tx_take,
  input wire logic        o_txd,
  input wire logic        o_tx_stalled,
  input wire logic        i_rx_done,
  input wire logic        i_rx_head_new,
  input wire logic        i_rx_fifo_full,
  input wire logic        i_rx_fifo_empty,
  input wire logic        o_rx_push,
  // Interrupt.
  input wire logic        o_modem_irq
);
  logic msi_en;
  logic auto_cts;

  // Shadow enables, written on the same edge as the block's own registers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      msi_en   <= 1'b0;
      auto_cts <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == ums_pkg::IRQ_ENABLE_ALT_OFS) msi_en <= i_wdata[ums_pkg::MSI_EN_BIT];
      if (i_addr == ums_pkg::MODEM_CONTROL_OFS) auto_cts <= i_wdata[ums_pkg::AUTO_CTS_BIT];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_lsr_read;
    i_rd && i_addr == ums_pkg::LINE_STATUS_OFS;
  endsequence
  sequence s_quiet_read;
    s_lsr_read ##0 !(i_rx_done || i_rx_head_new);
  endsequence
  sequence s_overrun;
    i_rx_done && i_rx_fifo_full;
  endsequence

  a_msi_off_quiet: assert property (!msi_en |-> !o_modem_irq)
    else $error("modem interrupt with master enable clear");
  a_push_gate: assert property (o_rx_push == (i_rx_done && !i_rx_fifo_full))
    else $error("receive push does not follow fifo full");
  a_oe_set: assert property (s_overrun ##1 !i_rd ##1 s_lsr_read |=> o_rdata[1])
    else $error("overrun not reported");
  a_flags_clear: assert property (s_quiet_read ##1 s_quiet_read |=> o_rdata[2:1] == 2'h0)
    else $error("status read did not clear error flags");
  a_rdr_follows: assert property (s_lsr_read ##0 $stable(i_rx_fifo_empty)
    |=> o_rdata[0] == !$past(i_rx_fifo_empty))
    else $error("data ready does not follow fifo level");
  a_start_bit: assert property (o_tx_take |=> !o_txd [*2])
    else $error("no start bit after take");
  a_no_retake: assert property (o_tx_take |=> !o_tx_take [*8])
    else $error("character cut short by a new take");
  a_stall_marks: assert property (o_tx_stalled |-> o_txd)
    else $error("stalled line not marking");
  a_stall_auto: assert property (o_tx_stalled |-> auto_cts || $past(auto_cts))
    else $error("stall without auto clear-to-send");
endmodule : ums_checker

bind ums_top ums_checker #(.CLKS_PER_BIT(CLKS_PER_BIT)) ums_checker_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_tx_take(o_tx_take), .o_txd(o_txd),
  .o_tx_stalled(o_tx_stalled), .i_rx_done(i_rx_done), .i_rx_head_new(i_rx_head_new),
  .i_rx_fifo_full(i_rx_fifo_full), .i_rx_fifo_empty(i_rx_fifo_empty),
  .o_rx_push(o_rx_push), .o_modem_irq(o_modem_irq));

// ==== ums_remote.sv ====
// Model of the remote party: drives clear-to-send and decodes the serial stream.
`timescale 1ns/1ps

module ums_remote #(
  parameter int CLKS_PER_BIT = 4
) (
  // Clock.
  input  wire logic       i_clk,
  // Serial line and flow control.
  input  wire logic       i_txd,
  input  wire logic       i_release,
  output logic            o_cts_n,
  // Decoded characters.
  output logic      [7:0] o_byte,
  output logic      [7:0] o_count
);
  // Clear-to-send follows the command, which is dropped well before mid stop bit.
  assign o_cts_n = i_release;

  // Samples each bit near its middle on the falling clock edge, away from txd updates.
  initial begin
    o_byte  = 8'h00;
    o_count = 8'h00;
    forever begin
      @(negedge i_clk);
      if (i_txd === 1'b0) begin
        repeat (CLKS_PER_BIT / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (CLKS_PER_BIT) @(negedge i_clk);
          o_byte[i] = i_txd;
        end
        repeat (CLKS_PER_BIT) @(negedge i_clk);
        if (i_txd === 1'b1) o_count = o_count + 8'h01;
      end
    end
  end
endmodule : ums_remote

// ==== testbench.sv ====
// Self-checking bench for the modem interrupt and line status block.
`timescale 1ns/1ps

module testbench;
  // Stimulus and observed signals.
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, cts_n;
  logic [31:0] i_addr = 32'h0;
  logic [7:0]  i_wdata = 8'h00, i_tx_data = 8'h00, o_rdata, rem_byte, rem_count;
  logic [3:0]  pins_n = 4'hf;
  logic [2:0]  rx_in = 3'h0;
  logic        i_tx_valid = 1'b0, full = 1'b0, empty = 1'b1;
  logic        o_tx_take, o_txd, o_tx_stalled, o_rx_push, o_modem_irq, o_irq;
  int          num_errors = 0, comparisons = 0;

  ums_top #(.CLKS_PER_BIT(4)) ums_top_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_cts_n(cts_n), .i_dsr_n(pins_n[1]), .i_ri_n(pins_n[3]),
    .i_dcd_n(pins_n[2]), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_take(o_tx_take),
    .o_txd(o_txd), .o_tx_stalled(o_tx_stalled), .i_rx_done(rx_in[0]),
    .i_rx_parity_bad(rx_in[1]), .i_rx_head_new(rx_in[2]), .i_rx_head_parity_bad(rx_in[1]),
    .i_rx_fifo_full(full), .i_rx_fifo_empty(empty), .o_rx_push(o_rx_push),
    .o_modem_irq(o_modem_irq), .o_irq(o_irq));
  ums_remote #(.CLKS_PER_BIT(4)) ums_remote_inst (.i_clk(i_clk), .i_txd(o_txd),
    .i_release(pins_n[0]), .o_cts_n(cts_n), .o_byte(rem_byte), .o_count(rem_count));

  // Clock of 40 ns.
  always #20 i_clk = ~i_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Reads n times back to back; f keeps the first answer, v the last.
  task automatic rd(input logic [31:0] a, input int n, output logic [7:0] f, output logic [7:0] v);
    @(posedge i_clk);
    {i_addr, i_rd} <= {a, 1'b1};
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      if (i == n - 1) i_rd <= 1'b0;
      #1 v = o_rdata;
      if (i == 0) f = v;
    end
  endtask : rd

  // The take is combinational, so it is looked for at the falling edge before the
  // rising edge that pops the byte; the task returns on that rising edge.
  task automatic wait_take;
    int n = 0;
    @(negedge i_clk);
    while (o_tx_take !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    check(8'(o_tx_take), 8'h01);
    @(posedge i_clk);
  endtask : wait_take

  task automatic wait_rx(input logic [7:0] c);
    for (int n = 0; n < 400 && rem_count !== c; n++) @(posedge i_clk);
    check(rem_count, c);
  endtask : wait_rx

  task automatic rx_ev(input logic [2:0] ev, input logic push);
    @(posedge i_clk);
    rx_in <= ev;
    #1 check(8'(o_rx_push), 8'(push));
    @(posedge i_clk);
    rx_in <= 3'h0;
  endtask : rx_ev

  task automatic t_rx;
    logic [7:0] f, v;
    wr(ums_pkg::LINE_STATUS_OFS, 8'hff);
    rd(ums_pkg::LINE_STATUS_OFS, 1, f, v);
    check(v & 8'h07, 8'h00);
    rd(32'h4000_8100, 1, f, v);
    check(v, 8'h00);
    full <= 1'b1;
    rx_ev(3'b001, 1'b0);
    rd(ums_pkg::LINE_STATUS_OFS, 2, f, v);
    check(8'({f[1], v[1]}), 8'h02);
    #1 check(8'(o_irq), 8'h00);
    wr(ums_pkg::EVENT_MASK_OFS, 8'h01);
    #1 check(8'(o_irq), 8'h01);
    rd(ums_pkg::EVENT_STATUS_OFS, 1, f, v);
    check(8'({v[ums_pkg::EV_OVERRUN], o_irq}), 8'h02);
    full <= 1'b0;
    rx_ev(3'b011, 1'b1);
    rd(ums_pkg::LINE_STATUS_OFS, 2, f, v);
    check(8'({f[2], v[2]}), 8'h02);
    wr(ums_pkg::FIFO_CONTROL_OFS, 8'h01);
    rx_ev(3'b011, 1'b1);
    rd(ums_pkg::LINE_STATUS_OFS, 1, f, v);
    check(8'(v[2]), 8'h00);
    rx_ev(3'b110, 1'b0);
    rd(ums_pkg::LINE_STATUS_OFS, 1, f, v);
    check(8'(v[2]), 8'h01);
    empty <= 1'b0;
    rd(ums_pkg::LINE_STATUS_OFS, 2, f, v);
    check(8'(v[0]), 8'h01);
    empty <= 1'b1;
    rd(ums_pkg::LINE_STATUS_OFS, 2, f, v);
    check(8'(v[0]), 8'h00);
  endtask : t_rx

  // Every mix of master enable, clear-to-send enable, auto mode and pin.
  task automatic t_modem;
    logic [7:0] f, v;
    for (int k = 0; k < 32; k++) begin
      wr(ums_pkg::IRQ_ENABLE_ALT_OFS, {4'h0, k[0], 3'h0});
      wr(ums_pkg::IRQ_ENABLE_OFS, {k[1], 7'h00});
      wr(ums_pkg::MODEM_CONTROL_OFS, {k[2], 7'h00});
      pins_n[k[4:3]] <= 1'b0;
      repeat (6) @(posedge i_clk);
      pins_n <= 4'hf;
      repeat (6) @(posedge i_clk);
      #1 check(8'(o_modem_irq), 8'(k[0] & (k[4:3] != 0 | !k[2] | k[1])));
      rd(ums_pkg::MODEM_STATUS_OFS, 1, f, v);
      check(8'({v[0], o_modem_irq}), 8'({k[4:3] == 0, 1'b0}));
    end
  endtask : t_modem

  task automatic t_tx;
    logic ok = 1'b1;
    wr(ums_pkg::MODEM_CONTROL_OFS, 8'h00);
    {i_tx_valid, i_tx_data} <= {1'b1, 8'h4b};
    wait_take;
    i_tx_valid <= 1'b0;
    wait_rx(8'd1);
    check(rem_byte, 8'h4b);
    wr(ums_pkg::MODEM_CONTROL_OFS, 8'h80);
    pins_n[0] <= 1'b0;
    repeat (4) @(posedge i_clk);
    {i_tx_valid, i_tx_data} <= {1'b1, 8'h1d};
    wait_take;
    i_tx_data <= 8'hb2;
    repeat (20) @(posedge i_clk);
    pins_n[0] <= 1'b1;
    wait_rx(8'd2);
    check(rem_byte, 8'h1d);
    repeat (30) @(posedge i_clk);
    repeat (100) begin
      @(posedge i_clk);
      #1 ok = ok && o_txd === 1'b1 && o_tx_stalled === 1'b1 && o_tx_take === 1'b0;
    end
    check(8'(ok), 8'h01);
    pins_n[0] <= 1'b0;
    wait_take;
    i_tx_valid <= 1'b0;
    wait_rx(8'd3);
    check(rem_byte, 8'hb2);
  endtask : t_tx

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // Main sequence after a reset of three cycles.
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    t_rx;
    t_modem;
    t_tx;
    end_of_test;
  end

  // Watchdog that ends a hung run.
  initial begin
    #400000;
    num_errors++;
    end_of_test;
  end
endmodule : testbench
